/* verilog/slcdb_pkg.sv */
`default_nettype none
package slcdb_pkg;

  // serial timing
  localparam int CLOCK_HZ = 10_000_000;
  localparam int BAUD_RATE = 9600;
  localparam int BAUD_CYCLES = CLOCK_HZ / BAUD_RATE;
  localparam int FRAME_BITS = 10;

  // register byte offsets
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_PAIRS = 4'hc;

  // command word fields
  localparam int CMD_ARG_LSB = 0;
  localparam int CMD_ROW_LSB = 8;
  localparam int CMD_OP_LSB = 10;
  localparam int CMD_W = 12;

  // control and status bits
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLRERR_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EMPTY_BIT = 1;
  localparam int STAT_FULL_BIT = 2;
  localparam int STAT_ERR_BIT = 3;
  localparam logic CTRL_EN_RESET = 1'b0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // lcd command values
  localparam int INIT_LEN = 8;
  localparam int MAX_COL = 19;
  localparam logic [7:0] LCD_CLEAR = 8'h01;

  typedef enum logic [1:0] {
    OP_CURSOR,
    OP_CHAR,
    OP_CLEAR,
    OP_INIT
  } slcdb_op_t;

  typedef enum logic {
    S_IDLE,
    S_SEND
  } slcdb_seq_t;

  function automatic logic [7:0] initByte(input logic [2:0] idx);
    case (idx)
      3'h0, 3'h1, 3'h2: initByte = 8'h30;
      3'h3: initByte = 8'h38;
      3'h4: initByte = 8'h08;
      3'h5: initByte = 8'h01;
      3'h6: initByte = 8'h06;
      default: initByte = 8'h0c;
    endcase
  endfunction

  function automatic logic [7:0] rowBase(input logic [1:0] row);
    case (row)
      2'h0: rowBase = 8'h80;
      2'h1: rowBase = 8'hc0;
      2'h2: rowBase = 8'h94;
      default: rowBase = 8'hd4;
    endcase
  endfunction

endpackage
`default_nettype wire

/* verilog/slcdb_fifo_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface slcdb_fifo_if #(parameter int WIDTH = 12);
  logic wValid;
  logic wReady;
  logic [WIDTH-1:0] wData;
  logic rValid;
  logic rReady;
  logic [WIDTH-1:0] rData;
  modport src (output wValid, output wData, input wReady,
               input rValid, input rData, output rReady);
  modport buffer (input wValid, input wData, output wReady,
                  output rValid, output rData, input rReady);
endinterface
`default_nettype wire

/* verilog/slcdb_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module slcdb_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // both sides
  slcdb_fifo_if.buffer port
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [CW-1:0] count;
  logic outValid;
  logic [WIDTH-1:0] outData;
  logic push;
  logic popMem;

  assign port.wReady = (count != CW'(DEPTH));
  assign port.rValid = outValid;
  assign port.rData = outData;
  assign push = port.wValid && port.wReady;
  // output stage refills from memory when empty or being drained
  assign popMem = (count != '0) && (!outValid || port.rReady);

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr] <= port.wData;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= PW'(wrPtr + 1'b1);
      end
      if (popMem) begin
        rdPtr <= PW'(rdPtr + 1'b1);
      end
      if (push && !popMem) begin
        count <= CW'(count + 1'b1);
      end else if (!push && popMem) begin
        count <= CW'(count - 1'b1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (popMem) begin
      outValid <= 1'b1;
      outData <= mem[rdPtr];
    end else if (port.rReady) begin
      outValid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* verilog/slcdb_host.sv */
// Notes on behaviour
// - send 9600 baud, start, eight bits, stop
// - always control frame then data frame
// - control bit1 select, bit2 strobe; data bits
// - byte with strobe low, high, then low
// - init sends eight fixed bytes, select low
// - clear sends 0x01 with select low
// - character write uses select high
// - cursor value is row base plus column
// - reject rows above 3, columns above 19
// - cursor command sets location first
// - character command writes at current location
// - clear command issues clear sequence
// - queued commands execute in order
`timescale 1ns/10ps
`default_nettype none
module slcdb_host import slcdb_pkg::*; #(
  parameter int ADDR_W = 4,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial line to the bridge
  output logic serialTx
);

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    isMapped = (addr == ADDR_W'(REG_CMD)) || (addr == ADDR_W'(REG_STATUS))
            || (addr == ADDR_W'(REG_CTRL)) || (addr == ADDR_W'(REG_PAIRS));
  endfunction

  // op field of a queued command word
  function automatic slcdb_op_t cmdOp(input logic [CMD_W-1:0] word);
    cmdOp = slcdb_op_t'(word[CMD_OP_LSB +: 2]);
  endfunction

  // the queue's output register holds one word beyond its depth
  slcdb_fifo_if #(.WIDTH(CMD_W)) cmdQ ();

  slcdb_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .port(cmdQ.buffer)
  );

  // register state
  logic enable;
  logic rangeErr;
  logic [15:0] pairCount;
  logic ctrlWrite;

  // write channel state
  logic haveAw;
  logic haveW;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrReady;
  logic doWrite;

  // sequencer state
  slcdb_seq_t seqState;
  slcdb_op_t curOp;
  logic [7:0] curArg;
  logic [1:0] curRow;
  logic [2:0] byteIdx;
  logic [1:0] phase;
  logic dataHalf;
  logic txGo;
  logic [7:0] frameByte;
  logic [7:0] lcdByte;
  logic [2:0] lastIdx;
  logic rsLevel;
  logic strobeLevel;
  logic accept;
  logic badCursor;

  // transmitter state
  logic txBusy;
  logic [$clog2(BAUD_CYCLES)-1:0] baudCnt;
  logic [3:0] bitCnt;
  logic [8:0] shift;
  logic baudTick;

  // ---------------- axi write ----------------
  // a command write waits for room in the queue; that is the back-pressure
  assign wrReady = (wrAddr != ADDR_W'(REG_CMD)) || cmdQ.wReady;
  assign doWrite = haveAw && haveW && !s_axi_bvalid && wrReady;
  assign cmdQ.wValid = haveAw && haveW && !s_axi_bvalid
                    && (wrAddr == ADDR_W'(REG_CMD));
  assign cmdQ.wData = wrData[CMD_W-1:0];
  // a control write that carries byte lane 0
  assign ctrlWrite = doWrite && (wrAddr == ADDR_W'(REG_CTRL)) && wrStrb[0];

  // ready pulses for one cycle, one write in flight at a time
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      haveAw <= 1'b0;
      wrAddr <= '0;
    end else begin
      s_axi_awready <= !s_axi_awready && s_axi_awvalid && !haveAw
                    && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        haveAw <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b0;
      haveW <= 1'b0;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
    end else begin
      s_axi_wready <= !s_axi_wready && s_axi_wvalid && !haveW
                   && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        haveW <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        haveW <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= isMapped(wrAddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enable <= CTRL_EN_RESET;
    end else if (ctrlWrite) begin
      enable <= wrData[CTRL_EN_BIT];
    end
  end

  // a new range fault wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rangeErr <= 1'b0;
    end else if (accept && badCursor) begin
      rangeErr <= 1'b1;
    end else if (ctrlWrite && wrData[CTRL_CLRERR_BIT]) begin
      rangeErr <= 1'b0;
    end
  end

  // ---------------- axi read ----------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      // status is taken at the address handshake
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        s_axi_rdata <= 32'h0000_0000;
        if (s_axi_araddr == ADDR_W'(REG_STATUS)) begin
          s_axi_rdata[STAT_BUSY_BIT] <= (seqState != S_IDLE) || txBusy;
          s_axi_rdata[STAT_EMPTY_BIT] <= !cmdQ.rValid;
          s_axi_rdata[STAT_FULL_BIT] <= !cmdQ.wReady;
          s_axi_rdata[STAT_ERR_BIT] <= rangeErr;
        end else if (s_axi_araddr == ADDR_W'(REG_CTRL)) begin
          s_axi_rdata[CTRL_EN_BIT] <= enable;
        end else if (s_axi_araddr == ADDR_W'(REG_PAIRS)) begin
          s_axi_rdata[15:0] <= pairCount;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- sequencer ----------------
  assign accept = (seqState == S_IDLE) && enable && cmdQ.rValid;
  assign cmdQ.rReady = accept;
  // a rejected cursor is popped and dropped without sending a frame
  assign badCursor = (cmdOp(cmdQ.rData) == OP_CURSOR)
                  && (cmdQ.rData[CMD_ARG_LSB +: 8] > 8'(MAX_COL));

  always_comb begin
    unique case (curOp)
      OP_CURSOR: lcdByte = 8'(rowBase(curRow) + curArg);
      OP_CHAR: lcdByte = curArg;
      OP_CLEAR: lcdByte = LCD_CLEAR;
      OP_INIT: lcdByte = initByte(byteIdx);
    endcase
  end

  assign lastIdx = (curOp == OP_INIT) ? 3'(INIT_LEN - 1) : 3'h0;
  assign rsLevel = (curOp == OP_CHAR);
  assign strobeLevel = (phase == 2'h1);
  // control frame first, then the byte; bit 1 on the wire is bit 0 here
  assign frameByte = dataHalf ? lcdByte
                   : {6'h00, strobeLevel, rsLevel};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seqState <= S_IDLE;
      curOp <= OP_CURSOR;
      curArg <= 8'h00;
      curRow <= 2'h0;
      byteIdx <= 3'h0;
      phase <= 2'h0;
      dataHalf <= 1'b0;
      txGo <= 1'b0;
    end else begin
      txGo <= 1'b0;
      unique case (seqState)
        S_IDLE: begin
          if (accept && !badCursor) begin
            curOp <= cmdOp(cmdQ.rData);
            curArg <= cmdQ.rData[CMD_ARG_LSB +: 8];
            curRow <= cmdQ.rData[CMD_ROW_LSB +: 2];
            byteIdx <= 3'h0;
            phase <= 2'h0;
            dataHalf <= 1'b0;
            seqState <= S_SEND;
          end
        end
        S_SEND: begin
          // launch the next frame once the line is free
          if (!txBusy && !txGo) begin
            txGo <= 1'b1;
            dataHalf <= !dataHalf;
            if (dataHalf) begin
              // strobe low, high, low around each byte
              if (phase == 2'h2) begin
                phase <= 2'h0;
                byteIdx <= 3'(byteIdx + 1'b1);
                if (byteIdx == lastIdx) begin
                  seqState <= S_IDLE;
                end
              end else begin
                phase <= 2'(phase + 1'b1);
              end
            end
          end
        end
      endcase
    end
  end

  // frame byte is held in goByte at launch, since the sequencer moves on before the transmitter loads it on txGo
  logic [7:0] goByte;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      goByte <= 8'h00;
      pairCount <= 16'h0000;
    end else if (seqState == S_SEND && !txBusy && !txGo) begin
      goByte <= frameByte;
      if (dataHalf) begin
        pairCount <= 16'(pairCount + 1'b1);
      end
    end
  end

  // ---------------- transmitter ----------------
  // the divisor truncates, so each bit runs slightly short
  assign baudTick = (baudCnt == ($clog2(BAUD_CYCLES))'(BAUD_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      serialTx <= 1'b1;
      txBusy <= 1'b0;
      baudCnt <= '0;
      bitCnt <= 4'h0;
      shift <= 9'h1ff;
    end else if (txGo) begin
      serialTx <= 1'b0;
      txBusy <= 1'b1;
      baudCnt <= '0;
      bitCnt <= 4'h0;
      shift <= {1'b1, goByte};
    end else if (txBusy) begin
      if (baudTick) begin
        baudCnt <= '0;
        if (bitCnt == 4'(FRAME_BITS - 1)) begin
          txBusy <= 1'b0;
        end else begin
          serialTx <= shift[0];
          shift <= {1'b1, shift[8:1]};
          bitCnt <= 4'(bitCnt + 1'b1);
        end
      end else begin
        baudCnt <= ($clog2(BAUD_CYCLES))'(baudCnt + 1'b1);
      end
    end
  end

endmodule
`default_nettype wire

/* dv/slcdb_host_props.sv */
`timescale 1ns/10ps
`default_nettype none
module slcdb_host_props import slcdb_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // axi handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial line
  input wire logic serialTx
);
  logic [31:0] lowRun;
  logic [31:0] highRun;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // length of the current low and high runs of the line
  always_ff @(posedge clock) begin
    if (!rst_n || serialTx) lowRun <= 32'h0000_0000;
    else lowRun <= lowRun + 32'h0000_0001;
  end
  // reset holds the line high, so a frame may start right after it
  always_ff @(posedge clock) begin
    if (!rst_n) highRun <= 32'h0001_0000;
    else if (!serialTx) highRun <= 32'h0000_0000;
    else if (highRun < 32'h0001_0000) highRun <= highRun + 32'h0000_0001;
  end
  a_reset_idle: assert property (disable iff (1'b0)
    !rst_n |=> serialTx && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");
  a_low_bits: assert property ($rose(serialTx) |->
    lowRun != 0 && lowRun % BAUD_CYCLES == 0)
    else $error("low run is not whole bits");
  a_stop_high: assert property ($fell(serialTx) |->
    highRun >= BAUD_CYCLES)
    else $error("stop bit too short");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready longer than one cycle");
endmodule
bind slcdb_host slcdb_host_props slcdb_host_props_inst (.clock, .rst_n,
  .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .serialTx);
`default_nettype wire

/* dv/slcdb_bridge_model.sv */
`timescale 1ns/10ps
`default_nettype none
module slcdb_bridge_model import slcdb_pkg::*; (
  // clock
  input wire logic clock,
  // serial in
  input wire logic serialIn,
  // lcd side
  output var logic registerSelect,
  output var logic lcdStrobe,
  output var logic [7:0] lcdData,
  output var logic stopError
);
  logic dataFrame;
  logic [7:0] shiftReg;
  // power-up state, no reset pin
  initial begin
    dataFrame = 1'b0;
    registerSelect = 1'b0;
    lcdStrobe = 1'b0;
    lcdData = 8'h00;
    stopError = 1'b0;
  end
  always begin
    @(negedge serialIn);
    repeat (BAUD_CYCLES / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_CYCLES) @(posedge clock);
      shiftReg[i] = serialIn;
    end
    repeat (BAUD_CYCLES) @(posedge clock);
    if (!serialIn) stopError = 1'b1;
    if (dataFrame) begin
      lcdData = shiftReg;
    end else begin
      registerSelect = shiftReg[0];
      lcdStrobe = shiftReg[1];
    end
    dataFrame = ~dataFrame;
  end
endmodule
`default_nettype wire

/* dv/slcdb_host_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module slcdb_host_tb import slcdb_pkg::*;;
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [31:0] data;
    logic [1:0] resp;
  } slcdb_row_t;
  slcdb_row_t rows [7] = '{
    '{1'b0, REG_STATUS, 32'h0000_0002, RESP_OKAY},
    '{1'b0, REG_CTRL, 32'h0000_0000, RESP_OKAY},
    '{1'b0, REG_PAIRS, 32'h0000_0000, RESP_OKAY},
    '{1'b1, REG_CTRL, 32'h0000_0000, RESP_OKAY},
    '{1'b1, 4'h6, 32'h0000_0001, RESP_SLVERR},
    '{1'b0, 4'h6, 32'h0000_0000, RESP_SLVERR},
    '{1'b0, REG_CTRL, 32'h0000_0000, RESP_OKAY}};
  logic clock = 1'b0;
  logic rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, serialTx;
  logic registerSelect, lcdStrobe, stopError;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] lcdData;
  logic [8:0] latched [$];
  int checks = 0;
  int mismatches = 0;
  slcdb_host #(.ADDR_W(4), .FIFO_DEPTH(8)) slcdb_host_inst (.clock, .rst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serialTx);
  slcdb_bridge_model slcdb_bridge_model_inst (.clock, .serialIn(serialTx),
    .registerSelect, .lcdStrobe, .lcdData, .stopError);
  always #50 clock = ~clock;
  // byte the display would take on the falling strobe
  always @(negedge lcdStrobe) begin
    if (rst_n === 1'b1) latched.push_back({registerSelect, lcdData});
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d,
                          output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic axiRead(input logic [3:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic pulseReset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (115000) @(posedge clock);
    mismatches++;
    print_verdict;
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h00_0000_0000;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      if (rows[i].wr) axiWrite(rows[i].addr, rows[i].data, resp);
      else axiRead(rows[i].addr, rd, resp);
      if (!rows[i].wr) check(rd, rows[i].data);
      check({30'h0, resp}, {30'h0, rows[i].resp});
    end
    // fill the queue while disabled, then flush it by reset
    // nine words: eight in the queue, one in its output register
    repeat (9) axiWrite(REG_CMD, 32'h0000_0441, resp);
    axiRead(REG_STATUS, rd, resp);
    check(rd, 32'h0000_0004);
    pulseReset;
    axiRead(REG_STATUS, rd, resp);
    check(rd, 32'h0000_0002);
    // column 20 must be dropped, row 3 column 1 sent
    axiWrite(REG_CMD, 32'h0000_0014, resp);
    axiWrite(REG_CMD, 32'h0000_0301, resp);
    axiWrite(REG_CTRL, 32'h0000_0001, resp);
    do axiRead(REG_PAIRS, rd, resp); while (rd !== 32'h0000_0003);
    do axiRead(REG_STATUS, rd, resp); while (rd[STAT_BUSY_BIT] !== 1'b0);
    check(rd, 32'h0000_000a);
    check({23'h0, latched[0]}, 32'h0000_00d5);
    check(latched.size(), 1);
    check({23'h0, registerSelect, lcdData}, 32'h0000_00d5);
    check({31'h0, lcdStrobe}, 32'h0000_0000);
    check({31'h0, stopError}, 32'h0000_0000);
    axiRead(REG_PAIRS, rd, resp);
    check(rd, 32'h0000_0003);
    axiWrite(REG_CTRL, 32'h0000_0002, resp);
    axiRead(REG_STATUS, rd, resp);
    check(rd, 32'h0000_0002);
    // first pair of a character write, cut by reset at the pair's end
    axiWrite(REG_CMD, 32'h0000_0441, resp);
    axiWrite(REG_CTRL, 32'h0000_0001, resp);
    @(lcdData);
    check({23'h0, registerSelect, lcdData}, 32'h0000_0141);
    @(posedge clock);
    pulseReset;
    // first pair of a clear
    axiWrite(REG_CMD, 32'h0000_0800, resp);
    axiWrite(REG_CTRL, 32'h0000_0001, resp);
    @(lcdData);
    check({23'h0, registerSelect, lcdData}, 32'h0000_0001);
    check(latched.size(), 1);
    print_verdict;
  end
endmodule
`default_nettype wire
